// file: rtl/overflow_cfg_consts.svh
// Offsets, field positions and fixed values of the overflow function's configuration header.
`ifndef OVERFLOW_CFG_CONSTS_SVH
`define OVERFLOW_CFG_CONSTS_SVH

// Register indexes; the Wishbone byte address is four times the index.
`define OVF_IDX_COMMAND   8'h04
`define OVF_IDX_STATUS    8'h06
`define OVF_IDX_STEPPING  8'h08
`define OVF_IDX_SUB_CAT   8'h0A
`define OVF_IDX_MAIN_CAT  8'h0B
`define OVF_IDX_HEADER    8'h0E
`define OVF_IDX_BASE      8'h10

// Command field positions.
`define OVF_CMD_IO_BIT    0
`define OVF_CMD_MEM_BIT   1

// Fixed read values.
`define OVF_STATUS_VALUE  16'h0080
`define OVF_SEL_TIMING    2'h0
`define OVF_B2B_CAP       1'h1
`define OVF_SUB_CAT_VALUE 8'h80
`define OVF_MAIN_CAT_VAL  8'h08
`define OVF_HEADER_VALUE  8'h00
`define OVF_BASE_MASK     8'h00
`define OVF_MEM_TYPE      2'h0
`define OVF_SPACE_IND     1'h0
`define OVF_PREFETCH      1'h0

// Base field width and position.
`define OVF_BASE_LSB      12
`define OVF_BASE_W        20

// Reset values of stored state.
`define OVF_RST_EN        1'h0
`define OVF_RST_BASE      20'h00000

`endif

// file: rtl/overflow_cfg_pkg.sv
// Types shared by the overflow function's configuration header.
package overflow_cfg_pkg;

  // Complete state of the header block.
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
    logic        mem_en;
    logic        io_en;
    logic [19:0] base;
  } hdr_state_type;

endpackage : overflow_cfg_pkg

// file: rtl/overflow_device_config_header.sv
// Configuration header of the overflow function with a classic Wishbone slave.
//
// Summary of operation
// RULE_01 - Command bits 9 to 2 always read zero; writes to them are dropped.
// RULE_02 - Command bit 1 enables memory space, read/write, resets to zero.
// RULE_03 - Command bit 0 enables the I/O range decode, read/write, resets to zero.
// RULE_04 - Status bits 15 to 11 and bit 8 are fixed zero, read-only.
// RULE_05 - Status bits 10:9 read 00b, fast select timing.
// RULE_06 - Status bit 7 reads one; the status register is read-only.
// RULE_07 - Stepping register is read-only and mirrors the primary function's stepping.
// RULE_08 - Sub-category register reads 80h.
// RULE_09 - Main category register reads 08h.
// RULE_10 - Header kind register reads 00h.
// RULE_11 - Software writes window base bits 31:12; stored, reset to zero.
// RULE_12 - Base bits 11:4 read 00h and ignore writes, giving a 4 KB window.
// RULE_13 - Base bit 3 is read-only and reports prefetchability.
// RULE_14 - Base bits 2:1 read 00b, window anywhere in 32-bit space.
// RULE_15 - Base bit 0 reads zero, marking memory space.
// RULE_16 - The window is claimed only while memory space is enabled.
// RULE_17 - Software uses single aligned window accesses of at most four bytes.
// RULE_18 - Reserved command and status bits read zero; writes have no effect.
// RULE_19 - Unimplemented header offsets read zero; writes there are discarded.
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "overflow_cfg_consts.svh"

module overflow_device_config_header (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [9:2]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  input  wire logic [7:0]  stepping_code_i,
  input  wire logic        win_req_i,
  input  wire logic [31:0] win_adr_i,
  output logic             win_claim_o,
  output logic             mem_space_en_o,
  output logic             io_space_en_o,
  output logic [31:12]     window_base_o
);

  overflow_cfg_pkg::hdr_state_type state;
  overflow_cfg_pkg::hdr_state_type next_state;
  logic [7:0]  idx;
  logic [31:0] rd_data;
  logic        wr_commit;

  assign idx = adr_i;

  // Read multiplexer; everything not listed reads zero, including all reserved bits.
  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (idx)
      `OVF_IDX_COMMAND: begin
        rd_data[15:10]            = 6'h00; // RULE_18
        rd_data[9:2]              = 8'h00; // RULE_01
        rd_data[`OVF_CMD_MEM_BIT] = state.mem_en; // RULE_02
        rd_data[`OVF_CMD_IO_BIT]  = state.io_en; // RULE_03
      end
      `OVF_IDX_STATUS: begin
        rd_data[15:11] = 5'h00; // RULE_04
        rd_data[10:9]  = `OVF_SEL_TIMING; // RULE_05
        rd_data[8]     = 1'h0; // RULE_04
        rd_data[7]     = `OVF_B2B_CAP; // RULE_06
        rd_data[6:0]   = 7'h00; // RULE_18
      end
      `OVF_IDX_STEPPING: rd_data[7:0]  = stepping_code_i; // RULE_07
      `OVF_IDX_SUB_CAT:  rd_data[7:0]  = `OVF_SUB_CAT_VALUE; // RULE_08
      `OVF_IDX_MAIN_CAT: rd_data[7:0]  = `OVF_MAIN_CAT_VAL; // RULE_09
      `OVF_IDX_HEADER:   rd_data[7:0]  = `OVF_HEADER_VALUE; // RULE_10
      `OVF_IDX_BASE: begin
        rd_data[31:12] = state.base; // RULE_11
        rd_data[11:4]  = `OVF_BASE_MASK; // RULE_12
        rd_data[3]     = `OVF_PREFETCH; // RULE_13
        rd_data[2:1]   = `OVF_MEM_TYPE; // RULE_14
        rd_data[0]     = `OVF_SPACE_IND; // RULE_15
      end
      default: rd_data = 32'h0000_0000; // RULE_19
    endcase
  end

  // A write lands on the edge at which the master sees ack, never earlier.
  assign wr_commit = cyc_i & stb_i & we_i & state.ack;

  // Next-state logic: one-wait-state ack, read data latched with the ack.
  always_comb begin
    next_state     = state;
    next_state.ack = cyc_i & stb_i & ~state.ack;
    next_state.dat = (cyc_i & stb_i & ~we_i & ~state.ack) ? rd_data : 32'h0000_0000;
    if (wr_commit && idx == `OVF_IDX_COMMAND && sel_i[0]) begin
      // Only the two enables are stored; bits 15:2 have no storage at all.
      next_state.mem_en = dat_i[`OVF_CMD_MEM_BIT]; // RULE_02
      next_state.io_en  = dat_i[`OVF_CMD_IO_BIT]; // RULE_03
    end
    if (wr_commit && idx == `OVF_IDX_BASE) begin
      if (sel_i[1]) begin
        next_state.base[3:0] = dat_i[15:12]; // RULE_11
      end
      if (sel_i[2]) begin
        next_state.base[11:4] = dat_i[23:16]; // RULE_11
      end
      if (sel_i[3]) begin
        next_state.base[19:12] = dat_i[31:24]; // RULE_11
      end
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state.ack    <= 1'h0;
      state.dat    <= 32'h0000_0000;
      state.mem_en <= `OVF_RST_EN;
      state.io_en  <= `OVF_RST_EN;
      state.base   <= `OVF_RST_BASE;
    end else begin
      state <= next_state;
    end
  end

  assign ack_o          = state.ack;
  assign dat_o          = state.dat;
  assign mem_space_en_o = state.mem_en;
  assign io_space_en_o  = state.io_en;
  assign window_base_o  = state.base;

  // Window claim is combinational so the decode path adds no cycle; a stale base is impossible
  // because the base and enable are both registered.
  assign win_claim_o = win_req_i & state.mem_en
                     & (win_adr_i[31:12] == state.base); // RULE_16

  // Checks on the header's own outputs. A read check fires in the ack cycle, while dat_o
  // stands and the master still holds the address, so idx names the register being read.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Only the two enables may ever show in a command read.
  a_cmd_read_bits: assert property ( // RULE_01
      ack_o && !we_i && idx == `OVF_IDX_COMMAND
      |-> dat_o[31:2] == 30'h0000_0000 && dat_o[1] == mem_space_en_o)
    else $error("Command read shows a fixed bit set.");

  // Reserved command bits stay clear whatever was written before.
  a_cmd_reserved: assert property ( // RULE_18
      ack_o && !we_i && idx == `OVF_IDX_COMMAND
      |-> dat_o[15:10] == 6'h00)
    else $error("Reserved command bits read non-zero.");

  // The I/O enable reads back from its own flop.
  a_cmd_io_bit: assert property ( // RULE_03
      ack_o && !we_i && idx == `OVF_IDX_COMMAND
      |-> dat_o[0] == io_space_en_o)
    else $error("Command read does not show the I/O enable.");

  // A lane 0 command write lands on the edge where ack is seen.
  a_mem_en_write: assert property ( // RULE_02
      ack_o && cyc_i && stb_i && we_i && sel_i[0] && idx == `OVF_IDX_COMMAND
      |=> mem_space_en_o == $past(dat_i[1]))
    else $error("Memory enable did not take the written value.");

  // The same write sets the I/O enable from bit 0.
  a_io_en_write: assert property ( // RULE_03
      ack_o && cyc_i && stb_i && we_i && sel_i[0] && idx == `OVF_IDX_COMMAND
      |=> io_space_en_o == $past(dat_i[0]))
    else $error("I/O enable did not take the written value.");

  // Without a committed command write the memory enable never moves.
  a_mem_en_hold: assert property ( // RULE_02
      !(ack_o && cyc_i && stb_i && we_i && sel_i[0] && idx == `OVF_IDX_COMMAND)
      |=> $stable(mem_space_en_o))
    else $error("Memory enable changed without a command write.");

  // Without a committed command write the I/O enable never moves.
  a_io_en_hold: assert property ( // RULE_03
      !(ack_o && cyc_i && stb_i && we_i && sel_i[0] && idx == `OVF_IDX_COMMAND)
      |=> $stable(io_space_en_o))
    else $error("I/O enable changed without a command write.");

  // The whole status word is one fixed pattern.
  a_status_fixed: assert property ( // RULE_06
      ack_o && !we_i && idx == `OVF_IDX_STATUS
      |-> dat_o == 32'h0000_0080)
    else $error("Status read is not the fixed value.");

  // Error flags have no source in this function and stay clear.
  a_status_errors: assert property ( // RULE_04
      ack_o && !we_i && idx == `OVF_IDX_STATUS
      |-> dat_o[15:11] == 5'h00 && dat_o[8] == 1'h0)
    else $error("Status error flags read non-zero.");

  // Select timing reports the fastest decode.
  a_status_timing: assert property ( // RULE_05
      ack_o && !we_i && idx == `OVF_IDX_STATUS
      |-> dat_o[10:9] == 2'h0)
    else $error("Status select timing is not fast.");

  // Back-to-back capability is always advertised.
  a_status_capable: assert property ( // RULE_06
      ack_o && !we_i && idx == `OVF_IDX_STATUS
      |-> dat_o[7] == 1'h1)
    else $error("Status does not advertise back-to-back capability.");

  // Reserved status bits and the unused upper half read zero.
  a_status_reserved: assert property ( // RULE_18
      ack_o && !we_i && idx == `OVF_IDX_STATUS
      |-> dat_o[6:0] == 7'h00 && dat_o[31:16] == 16'h0000)
    else $error("Reserved status bits read non-zero.");

  // A status write has nowhere to land, so no stored state may move.
  a_status_no_store: assert property ( // RULE_06
      ack_o && we_i && idx == `OVF_IDX_STATUS
      |=> $stable(mem_space_en_o) && $stable(io_space_en_o) && $stable(window_base_o))
    else $error("A status write changed stored state.");

  // The stepping value is passed through as it stood when the read was taken.
  a_stepping_mirror: assert property ( // RULE_07
      ack_o && !we_i && idx == `OVF_IDX_STEPPING
      |-> dat_o == {24'h000000, $past(stepping_code_i)})
    else $error("Stepping read does not mirror the primary stepping.");

  // Class and header codes in one place, as a cross-check of the mux.
  a_class_codes: assert property ( // RULE_08
      ack_o && !we_i
      && (idx == `OVF_IDX_SUB_CAT || idx == `OVF_IDX_MAIN_CAT || idx == `OVF_IDX_HEADER)
      |-> dat_o == (idx == `OVF_IDX_SUB_CAT ? 32'h0000_0080 :
                    idx == `OVF_IDX_MAIN_CAT ? 32'h0000_0008 : 32'h0000_0000))
    else $error("Class or header code read is wrong.");

  // The main category names a system peripheral.
  a_main_category: assert property ( // RULE_09
      ack_o && !we_i && idx == `OVF_IDX_MAIN_CAT
      |-> dat_o == 32'h0000_0008)
    else $error("Main category read is wrong.");

  // The header kind names a single-function standard layout.
  a_header_kind: assert property ( // RULE_10
      ack_o && !we_i && idx == `OVF_IDX_HEADER
      |-> dat_o == 32'h0000_0000)
    else $error("Header kind read is wrong.");

  // The low twelve base bits never show stored state.
  a_base_low_bits: assert property ( // RULE_12
      ack_o && !we_i && idx == `OVF_IDX_BASE
      |-> dat_o[11:0] == 12'h000 && dat_o[31:12] == window_base_o)
    else $error("Base register low bits are not fixed.");

  // A full-word base write stores the upper field.
  a_base_write: assert property ( // RULE_11
      ack_o && cyc_i && stb_i && we_i && sel_i == 4'hF && idx == `OVF_IDX_BASE
      |=> window_base_o == $past(dat_i[31:12]))
    else $error("Base field did not take the written value.");

  // Without a committed base write the window stays where it is.
  a_base_hold: assert property ( // RULE_11
      !(ack_o && cyc_i && stb_i && we_i && idx == `OVF_IDX_BASE)
      |=> $stable(window_base_o))
    else $error("Window base moved without a base write.");

  // The top lane, left unselected, keeps its byte of the base.
  a_base_lane_top: assert property ( // RULE_11
      ack_o && cyc_i && stb_i && we_i && !sel_i[3] && idx == `OVF_IDX_BASE
      |=> window_base_o[31:24] == $past(window_base_o[31:24]))
    else $error("Unselected base lane was overwritten.");

  // The prefetch bit is the fixed choice of this block.
  a_base_prefetch: assert property ( // RULE_13
      ack_o && !we_i && idx == `OVF_IDX_BASE
      |-> dat_o[3] == `OVF_PREFETCH)
    else $error("Base prefetch bit is wrong.");

  // The window may sit anywhere in 32-bit space.
  a_base_mem_type: assert property ( // RULE_14
      ack_o && !we_i && idx == `OVF_IDX_BASE
      |-> dat_o[2:1] == 2'h0)
    else $error("Base memory type is wrong.");

  // The window is memory space, never I/O.
  a_base_space: assert property ( // RULE_15
      ack_o && !we_i && idx == `OVF_IDX_BASE
      |-> dat_o[0] == 1'h0)
    else $error("Base space indicator is wrong.");

  // A claim needs the enable and a base match.
  a_claim_gate: assert property ( // RULE_16
      win_claim_o
      |-> mem_space_en_o && win_adr_i[31:12] == window_base_o)
    else $error("Window claimed while disabled or outside the base.");

  // An enabled hit must be claimed in the same cycle.
  a_claim_hit: assert property ( // RULE_16
      win_req_i && mem_space_en_o && win_adr_i[31:12] == window_base_o
      |-> win_claim_o)
    else $error("Enabled window hit was not claimed.");

  // Nothing is claimed while memory space is off.
  a_claim_disabled: assert property ( // RULE_16
      !mem_space_en_o
      |-> !win_claim_o)
    else $error("Window claimed with memory space off.");

  // Nothing is claimed without a request.
  a_claim_no_req: assert property ( // RULE_16
      !win_req_i
      |-> !win_claim_o)
    else $error("Window claimed without a request.");

  // The left-out identification offset reads zero.
  a_unmapped_zero: assert property ( // RULE_19
      ack_o && !we_i && idx == 8'h00
      |-> dat_o == 32'h0000_0000)
    else $error("Unimplemented offset read non-zero.");

  // Every offset above the base register reads zero.
  a_unmapped_range: assert property ( // RULE_19
      ack_o && !we_i && idx > `OVF_IDX_BASE
      |-> dat_o == 32'h0000_0000)
    else $error("Offset above the base register read non-zero.");

  // A write above the base register leaves all stored state alone.
  a_unmapped_write: assert property ( // RULE_19
      ack_o && we_i && idx > `OVF_IDX_BASE
      |=> $stable(mem_space_en_o) && $stable(io_space_en_o) && $stable(window_base_o))
    else $error("A write to an unimplemented offset changed stored state.");

  // Every request gets one ack pulse after one wait state.
  a_ack_single: assert property (
      cyc_i && stb_i && !ack_o
      |=> ack_o ##1 !ack_o)
    else $error("Ack did not pulse for exactly one cycle.");

  // No ack without a request in the cycle before.
  a_ack_needs_req: assert property (
      ack_o
      |-> $past(cyc_i && stb_i))
    else $error("Ack without a preceding request.");

  // An idle bus is never acknowledged.
  a_ack_idle: assert property (
      !(cyc_i && stb_i)
      |=> !ack_o)
    else $error("Ack raised on an idle bus.");

  // Read data is forced to zero outside ack cycles.
  a_data_idle: assert property (
      !ack_o
      |-> dat_o == 32'h0000_0000)
    else $error("Read data not zero outside an ack cycle.");

  // Main scenarios worth seeing at least once.
  c_mem_enable: cover property (ack_o && we_i && idx == `OVF_IDX_COMMAND ##1 mem_space_en_o);
  c_io_enable: cover property (ack_o && we_i && idx == `OVF_IDX_COMMAND ##1 io_space_en_o);
  c_base_write: cover property (ack_o && we_i && idx == `OVF_IDX_BASE ##1 window_base_o != 20'h00000);
  c_window_claim: cover property (win_claim_o);
  c_status_read: cover property (ack_o && !we_i && idx == `OVF_IDX_STATUS);

endmodule : overflow_device_config_header
`default_nettype wire

// file: verif/cfg_host_model.sv
// Wishbone configuration master standing in for host software.
`timescale 1ns/10ps
`default_nettype none
module cfg_host_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [9:2]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o
);
  // Idle bus at time zero.
  initial {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;

  // One single aligned full-word cycle; data is inverted once released.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'h3, w, a, 4'hF, d};
    do @(posedge clk_i); while (ack_i !== 1'b1);
    r = dat_i;
    {cyc_o, stb_o, we_o} <= 3'h0;
    dat_o <= ~d;
  endtask : xfer
endmodule : cfg_host_model
`default_nettype wire

// file: verif/tb_overflow_device_config_header.sv
// Self-checking bench for the overflow configuration header.
`timescale 1ns/10ps
`default_nettype none
module tb_overflow_device_config_header;
  logic         clk_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         cyc, stb, we, ack, claim, mem_en, io_en;
  logic         req = 1'b0;
  logic [9:2]   adr;
  logic [3:0]   sel;
  logic [31:0]  wd, rdat, r;
  logic [31:0]  wadr = 32'h0;
  logic [7:0]   step = 8'h5A;
  logic [31:12] base;
  int           fail_count = 0;
  int           n_checks = 0;
  int           cycles = 0;

  // A 100 ns clock.
  always #50 clk_i = ~clk_i;

  overflow_device_config_header DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wd), .dat_o(rdat),
    .ack_o(ack), .stepping_code_i(step), .win_req_i(req), .win_adr_i(wadr),
    .win_claim_o(claim), .mem_space_en_o(mem_en), .io_space_en_o(io_en),
    .window_base_o(base));
  cfg_host_model host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc),
    .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wd));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    host.xfer(1'b0, a, 32'h0, r);
    chk($sformatf("reg %h", a), e, r);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, r);
  endtask : wr

  task t_regs;
    rd(8'h04, 32'h0);
    rd(8'h10, 32'h0);
    rd(8'h08, 32'h5A);
    step <= 8'hC3;
    rd(8'h08, 32'hC3);
    rd(8'h0A, 32'h80);
    rd(8'h0B, 32'h08);
    wr(8'h0E, 32'hFFFFFFFF);
    rd(8'h0E, 32'h0);
    wr(8'h06, 32'hFFFFFFFF);
    rd(8'h06, 32'h80);
    $display("done t_regs");
  endtask : t_regs

  task t_cmd;
    wr(8'h04, 32'hFFFFFFFF);
    rd(8'h04, 32'h3);
    wr(8'h04, 32'h1);
    @(negedge clk_i);
    chk("io_en", 32'h1, io_en);
    chk("mem_en", 32'h0, mem_en);
    wr(8'h10, 32'hFFFFFFFF);
    rd(8'h10, 32'hFFFFF000);
    wr(8'h10, 32'h12345ABC);
    rd(8'h10, 32'h12345000);
    chk("base", 32'h12345, {12'h0, base});
    $display("done t_cmd");
  endtask : t_cmd

  // The window is refused while memory space is off, then claimed by base only.
  task t_claim;
    req <= 1'b1;
    wadr <= 32'h12345FFC;
    @(negedge clk_i);
    chk("claim off", 32'h0, claim);
    wr(8'h04, 32'h2);
    @(negedge clk_i);
    chk("claim on", 32'h1, claim);
    @(posedge clk_i);
    wadr <= 32'h12346000;
    @(negedge clk_i);
    chk("claim miss", 32'h0, claim);
    wr(8'h14, 32'hFFFFFFFF);
    rd(8'h14, 32'h0);
    rd(8'h09, 32'h0);
    rd(8'h04, 32'h2);
    $display("done t_claim");
  endtask : t_claim

  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish

  // A hung handshake must not stall the run.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_cmd();
    t_claim();
    tally_and_finish();
  end
endmodule : tb_overflow_device_config_header
`default_nettype wire
